//--- shared/tpc_params.svh
// Register offsets, field positions and reset values of the timer/PWM core.
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
`define TPC_NCH        2
`define TPC_EXT_CH     0
`define TPC_SC_OFF     8'h00
`define TPC_CNT_OFF    8'h04
`define TPC_MOD_OFF    8'h08
`define TPC_CH_BASE    8'h10
`define TPC_CH_STRIDE  8'h08
`define TPC_CHV_OFF    8'h04
`define TPC_SC_FLAG    7
`define TPC_SC_IE      6
`define TPC_SC_CENTER_ALIGNED_PWM    5
`define TPC_SC_CS_HI   4
`define TPC_SC_CS_LO   3
`define TPC_SC_PS_HI   2
`define TPC_SC_PS_LO   0
`define TPC_CH_PULL    8
`define TPC_CH_FLAG    7
`define TPC_CH_IE      6
`define TPC_CH_MS_HI   5
`define TPC_CH_MS_LO   4
`define TPC_CH_EL_HI   3
`define TPC_CH_EL_LO   2
`define TPC_CS_NONE    2'h0
`define TPC_CS_BUS     2'h1
`define TPC_CS_FIXED   2'h2
`define TPC_CS_EXT     2'h3
`define TPC_MOD_RST    16'h0000
`define TPC_CNT_FULL   16'hFFFF
`endif

//--- shared/tpc_pkg.sv
// Types shared by the timer/PWM core.
package tpc_pkg;
    typedef enum logic [1:0] {
        TPC_UP   = 2'b01,
        TPC_DOWN = 2'b10
    } tpc_dir_e;
    typedef enum logic [3:0] {
        TPC_K_CAP  = 4'b0001,
        TPC_K_CMP  = 4'b0010,
        TPC_K_EPWM = 4'b0100,
        TPC_K_CENTER_ALIGNED_PWM = 4'b1000
    } tpc_kind_e;
    typedef logic [15:0] tpc_cnt_t;
endpackage : tpc_pkg

//--- verilog/tpc_core.sv
// Timer/PWM core: 16-bit counter, prescaler, channels and APB registers.
// Behaviour
// - 16-bit counter: free, modulo, up/down.
// - Modulo 0000 or FFFF means full range.
// - Any counter write clears the counter.
// - Counter reads never disturb counting.
// - Source 1:1 selects external pin clock.
// - External clock synchronised; keep at or below quarter rate.
// - Prescaler divides by 1 to 128.
// - One bit sets all channels center-aligned.
// - Channels independently capture, compare or PWM.
// - Capture on rising, falling or both edges.
// - Compare sets, clears or toggles pin.
// - Per-channel PWM output polarity.
// - Interrupt per channel plus overflow.
// - Clock-sharing channel leaves pin alone.
// - Timer-owned pin ignores port data/direction.
// - Pinless configuration returns pin to GPIO.
// - Reset: disabled, GPIO inputs, pullups off.
// - Timer input pin may enable pullup.
// - Source codes: none, bus, fixed, external.
// - Three-bit prescale after source selection.
// - Overflow flag on wrap or on the center-mode turn at the limit.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"
module tpc_core (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                fixed_system_clock,
    input  wire logic [`TPC_NCH-1:0] channel_pin_in,
    input  wire logic [`TPC_NCH-1:0] gpio_data,
    input  wire logic [`TPC_NCH-1:0] gpio_dir,
    output logic      [`TPC_NCH-1:0] channel_pin_out,
    output logic      [`TPC_NCH-1:0] channel_pin_oe,
    output logic      [`TPC_NCH-1:0] pin_pullup_en,
    output logic      [`TPC_NCH-1:0] channel_irq,
    output logic                     overflow_irq
);
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : hit

    function automatic tpc_pkg::tpc_kind_e kind_of(input logic cp, input logic [1:0] ms);
        if (cp) begin
            kind_of = tpc_pkg::TPC_K_CENTER_ALIGNED_PWM;
        end else if (ms[1]) begin
            kind_of = tpc_pkg::TPC_K_EPWM;
        end else if (ms[0]) begin
            kind_of = tpc_pkg::TPC_K_CMP;
        end else begin
            kind_of = tpc_pkg::TPC_K_CAP;
        end
    endfunction : kind_of

    logic                  overflow_flag;
    logic                  ovf_arm;
    logic                  ovf_ie;
    logic                  center_aligned_pwm;
    logic [1:0]            clock_source_select;
    logic [2:0]            prescale_select;
    tpc_pkg::tpc_cnt_t     counter_value;
    tpc_pkg::tpc_cnt_t     modulo_limit;
    tpc_pkg::tpc_cnt_t     lim;
    tpc_pkg::tpc_dir_e     dir;
    logic [6:0]            pre;
    logic [6:0]            pre_mask;
    logic [1:0]            sync1;
    logic [1:0]            sync2;
    logic [1:0]            sync3;
    logic [1:0]            edge_seen;
    logic                  src_tick;
    logic                  pre_tick;
    logic                  wrap;
    logic                  ovf_evt;
    logic                  ext_sel;
    logic                  acc_wr;
    logic                  acc_rd;
    logic                  setup_rd;
    logic                  sc_wr;
    logic                  sc_rd;
    logic                  cnt_wr;
    logic                  mapped;
    logic [31:0]           rd_mux;
    logic [31:0]           ch_rd [`TPC_NCH];
    logic [`TPC_NCH-1:0]   ch_hit;
    logic [`TPC_NCH-1:0]   uses_pin;

    assign acc_wr   = psel && penable && pwrite;
    assign acc_rd   = psel && penable && !pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign sc_wr    = acc_wr && hit(paddr, `TPC_SC_OFF);
    assign sc_rd    = acc_rd && hit(paddr, `TPC_SC_OFF);
    assign cnt_wr   = acc_wr && hit(paddr, `TPC_CNT_OFF);
    assign ext_sel  = (clock_source_select == `TPC_CS_EXT);

    // Zero wait states; an unmapped address answers with an error.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk) begin
        if (srst) begin
            ovf_ie              <= 1'b0;
            center_aligned_pwm  <= 1'b0;
            clock_source_select <= `TPC_CS_NONE;
            prescale_select     <= 3'h0;
        end else if (sc_wr) begin
            ovf_ie              <= pwdata[`TPC_SC_IE];
            center_aligned_pwm  <= pwdata[`TPC_SC_CENTER_ALIGNED_PWM];
            clock_source_select <= pwdata[`TPC_SC_CS_HI:`TPC_SC_CS_LO];
            prescale_select     <= pwdata[`TPC_SC_PS_HI:`TPC_SC_PS_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            modulo_limit <= `TPC_MOD_RST;
        end else if (acc_wr && hit(paddr, `TPC_MOD_OFF)) begin
            modulo_limit <= pwdata[15:0];
        end
    end

    // Fixed clock and the pin clock are both taken as levels and re-timed;
    // channel 0's pin doubles as the external clock input.
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
        end else begin
            sync1 <= {channel_pin_in[`TPC_EXT_CH], fixed_system_clock};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    assign edge_seen = sync2 & ~sync3;

    always_comb begin
        case (clock_source_select)
            `TPC_CS_NONE:  src_tick = 1'b0;
            `TPC_CS_BUS:   src_tick = 1'b1;
            `TPC_CS_FIXED: src_tick = edge_seen[0];
            `TPC_CS_EXT:   src_tick = edge_seen[1];
            default:       src_tick = 1'b0;
        endcase
    end

    // The divider sits after selection and synchronisation.
    assign pre_mask = 7'((8'h01 << prescale_select) - 8'h01);
    assign pre_tick = src_tick && ((pre & pre_mask) == pre_mask);

    always_ff @(posedge clk) begin
        if (srst || cnt_wr) begin
            pre <= 7'h00;
        end else if (src_tick) begin
            pre <= pre + 7'h01;
        end
    end

    assign lim  = (modulo_limit == `TPC_MOD_RST) ? `TPC_CNT_FULL : modulo_limit;
    assign wrap = (counter_value == lim) || (counter_value == `TPC_CNT_FULL);
    assign ovf_evt = pre_tick && !cnt_wr && (center_aligned_pwm ?
                     (dir == tpc_pkg::TPC_UP && counter_value == lim) : wrap);

    // Reads have no path into this process, so polling never perturbs counting.
    always_ff @(posedge clk) begin
        if (srst) begin
            counter_value <= 16'h0000;
            dir           <= tpc_pkg::TPC_UP;
        end else if (cnt_wr) begin
            counter_value <= 16'h0000;
            dir           <= tpc_pkg::TPC_UP;
        end else if (pre_tick) begin
            if (!center_aligned_pwm) begin
                dir           <= tpc_pkg::TPC_UP;
                counter_value <= wrap ? 16'h0000 : counter_value + 16'h0001;
            end else if (dir == tpc_pkg::TPC_UP) begin
                if (counter_value == lim) begin
                    dir           <= tpc_pkg::TPC_DOWN;
                    counter_value <= counter_value - 16'h0001;
                end else begin
                    counter_value <= counter_value + 16'h0001;
                end
            end else begin
                if (counter_value == 16'h0000) begin
                    dir           <= tpc_pkg::TPC_UP;
                    counter_value <= 16'h0001;
                end else begin
                    counter_value <= counter_value - 16'h0001;
                end
            end
        end
    end

    // Clearing needs a read that saw the flag set, then a write of zero.
    // A new overflow restarts that sequence and always wins over the clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            overflow_flag <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag <= 1'b1;
        end else if (sc_wr && ovf_arm && !pwdata[`TPC_SC_FLAG]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || ovf_evt) begin
            ovf_arm <= 1'b0;
        end else if (sc_rd && overflow_flag) begin
            ovf_arm <= 1'b1;
        end else if (sc_wr) begin
            ovf_arm <= 1'b0;
        end
    end

    assign overflow_irq = overflow_flag && ovf_ie;

    genvar n;
    generate
        for (n = 0; n < `TPC_NCH; n++) begin : g_ch
            localparam logic [7:0] CTL_A = 8'(`TPC_CH_BASE + n * `TPC_CH_STRIDE);
            localparam logic [7:0] VAL_A = 8'(CTL_A + `TPC_CHV_OFF);
            logic              ie;
            logic              pull;
            logic [1:0]        ms;
            logic [1:0]        els;
            logic              flag;
            logic              arm;
            logic              pin_q;
            logic              out_q;
            logic              pwm_hi;
            logic              shared;
            logic              cap_hit;
            logic              cmp_hit;
            logic              pwm_hit;
            logic              evt;
            logic              ctl_wr;
            logic              val_wr;
            tpc_pkg::tpc_cnt_t val;
            tpc_pkg::tpc_cnt_t act;
            tpc_pkg::tpc_kind_e kind;

            assign ctl_wr = acc_wr && hit(paddr, CTL_A);
            assign val_wr = acc_wr && hit(paddr, VAL_A);
            assign kind   = kind_of(center_aligned_pwm, ms);
            assign shared = ext_sel && (n == `TPC_EXT_CH);
            assign uses_pin[n] = (els != 2'h0) && !shared;
            assign ch_hit[n] = hit(paddr, CTL_A) || hit(paddr, VAL_A);
            assign ch_rd[n] = hit(paddr, CTL_A) ?
                              {23'h000000, pull, flag, ie, ms, els, 2'h0} :
                              {16'h0000, val};

            always_ff @(posedge clk) begin
                if (srst) begin
                    ie   <= 1'b0;
                    pull <= 1'b0;
                    ms   <= 2'h0;
                    els  <= 2'h0;
                end else if (ctl_wr) begin
                    ie   <= pwdata[`TPC_CH_IE];
                    pull <= pwdata[`TPC_CH_PULL];
                    ms   <= pwdata[`TPC_CH_MS_HI:`TPC_CH_MS_LO];
                    els  <= pwdata[`TPC_CH_EL_HI:`TPC_CH_EL_LO];
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    pin_q <= 1'b0;
                end else begin
                    pin_q <= channel_pin_in[n];
                end
            end

            assign cap_hit = (kind == tpc_pkg::TPC_K_CAP) && uses_pin[n] &&
                             ((els[0] && channel_pin_in[n] && !pin_q) ||
                              (els[1] && !channel_pin_in[n] && pin_q));
            // Compare still runs on a shared channel, as a software timer.
            assign cmp_hit = (kind == tpc_pkg::TPC_K_CMP) && pre_tick &&
                             (counter_value == val);
            assign pwm_hit = kind[2] | kind[3] ? (pre_tick && counter_value == act) : 1'b0;
            assign evt     = cap_hit || cmp_hit || pwm_hit;

            always_ff @(posedge clk) begin
                if (srst) begin
                    val <= 16'h0000;
                end else if (cap_hit) begin
                    val <= counter_value;
                end else if (val_wr) begin
                    val <= pwdata[15:0];
                end
            end

            // PWM duty is double-buffered and taken over at the period boundary,
            // so a mid-period write cannot produce a runt pulse.
            always_ff @(posedge clk) begin
                if (srst) begin
                    act <= 16'h0000;
                end else if (kind == tpc_pkg::TPC_K_CMP || kind == tpc_pkg::TPC_K_CAP) begin
                    act <= val;
                end else if (ovf_evt) begin
                    act <= val;
                end
            end

            assign pwm_hi = (counter_value < act);

            always_ff @(posedge clk) begin
                if (srst) begin
                    out_q <= 1'b0;
                end else if (kind == tpc_pkg::TPC_K_CMP) begin
                    if (cmp_hit && uses_pin[n]) begin
                        case (els)
                            2'h1:    out_q <= !out_q;
                            2'h2:    out_q <= 1'b0;
                            2'h3:    out_q <= 1'b1;
                            default: out_q <= out_q;
                        endcase
                    end
                end else if (kind != tpc_pkg::TPC_K_CAP) begin
                    out_q <= els[0] ? !pwm_hi : pwm_hi;
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    flag <= 1'b0;
                end else if (evt) begin
                    flag <= 1'b1;
                end else if (ctl_wr && arm && !pwdata[`TPC_CH_FLAG]) begin
                    flag <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (srst || evt) begin
                    arm <= 1'b0;
                end else if (acc_rd && hit(paddr, CTL_A) && flag) begin
                    arm <= 1'b1;
                end else if (ctl_wr) begin
                    arm <= 1'b0;
                end
            end

            assign channel_irq[n] = flag && ie;
            assign channel_pin_out[n] = uses_pin[n] ? out_q : gpio_data[n];
            assign channel_pin_oe[n]  = uses_pin[n] ? (kind != tpc_pkg::TPC_K_CAP)
                                                    : gpio_dir[n];
            assign pin_pullup_en[n] = uses_pin[n] && (kind == tpc_pkg::TPC_K_CAP) && pull;

            AST_GPIO_PASS: assert property (@(posedge clk) disable iff (srst)
                !uses_pin[n] |-> channel_pin_out[n] == gpio_data[n] &&
                                 channel_pin_oe[n] == gpio_dir[n])
                else $error("pin not returned to port control");
            AST_CAP_LATCH: assert property (@(posedge clk) disable iff (srst)
                cap_hit |=> val == $past(counter_value) && flag)
                else $error("capture did not latch the counter");
        end
    endgenerate

    always_comb begin
        rd_mux = 32'h00000000;
        mapped = 1'b1;
        if (hit(paddr, `TPC_SC_OFF)) begin
            rd_mux = {24'h000000, overflow_flag, ovf_ie, center_aligned_pwm,
                      clock_source_select, prescale_select};
        end else if (hit(paddr, `TPC_CNT_OFF)) begin
            rd_mux = {16'h0000, counter_value};
        end else if (hit(paddr, `TPC_MOD_OFF)) begin
            rd_mux = {16'h0000, modulo_limit};
        end else begin
            mapped = 1'b0;
            for (int i = 0; i < `TPC_NCH; i++) begin
                if (ch_hit[i]) begin
                    rd_mux = ch_rd[i];
                    mapped = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= rd_mux;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_FREE_WRAP: assert property (
        pre_tick && !cnt_wr && !center_aligned_pwm && counter_value == `TPC_CNT_FULL
        |=> counter_value == 16'h0000 && overflow_flag)
        else $error("counter did not wrap from full range");
    AST_CNT_WRITE: assert property (
        cnt_wr |=> counter_value == 16'h0000)
        else $error("counter write did not clear counter");
    AST_READ_QUIET: assert property (
        acc_rd && !pre_tick && !cnt_wr |=> $stable(counter_value))
        else $error("read disturbed the counter");
    AST_NO_SRC_HOLD: assert property (
        clock_source_select == `TPC_CS_NONE && !cnt_wr |=> $stable(counter_value))
        else $error("counter moved without a source");
    AST_BUS_STEP: assert property (
        clock_source_select == `TPC_CS_BUS && prescale_select == 3'h1 && !sc_wr &&
        !cnt_wr && pre_tick |=> !pre_tick)
        else $error("divide by two ticked twice in a row");
    AST_EXT_SYNC: assert property (
        ext_sel && src_tick |-> $past(channel_pin_in[0], 2) && !$past(channel_pin_in[0], 3))
        else $error("external tick not two cycles after pin edge");
    AST_CENTER_ALIGNED_PWM_TURN: assert property (
        pre_tick && !cnt_wr && center_aligned_pwm && dir == tpc_pkg::TPC_UP &&
        counter_value == lim |=> dir == tpc_pkg::TPC_DOWN && overflow_flag)
        else $error("center mode did not turn at the limit");
    AST_SHARED_PIN: assert property (
        ext_sel |-> !uses_pin[`TPC_EXT_CH])
        else $error("clock-sharing channel drives its pin");
    AST_RESET_IDLE: assert property (
        $past(srst) |-> uses_pin == '0 && pin_pullup_en == '0 && !overflow_irq)
        else $error("pins not released after reset");
    AST_OVF_IRQ: assert property (
        ovf_evt && ovf_ie |=> overflow_irq)
        else $error("overflow interrupt missing");

    COV_OVF: cover property (ovf_evt);
    COV_DOWN_TURN: cover property (pre_tick && center_aligned_pwm &&
        dir == tpc_pkg::TPC_DOWN && counter_value == 16'h0000);
    COV_EXT_TICK: cover property (ext_sel && pre_tick);
    COV_FLAG_CLEAR: cover property (overflow_flag ##1 !overflow_flag);
endmodule : tpc_core
`default_nettype wire

//--- tb/tpc_pins.sv
// Pin-side partner: external clock, capture stimulus and pin wire resolution.
`timescale 1ns/1ps
`default_nettype none
module tpc_pins (
    input  wire logic       clk,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] pull_en,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] drv_en,
    input  wire logic [1:0] drv_val,
    output logic      [1:0] pin_in
);
    logic [1:0] div = 2'h0;
    logic [1:0] last = 2'h0;
    // The external clock runs at a quarter of the bus rate, the fastest allowed.
    always_ff @(posedge clk) begin
        div  <= div + 2'h1;
        last <= pin_in;
    end
    // A floating pin shows the inverse of its last level, so nothing can rely on it.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = div[1];
            else if (drv_en[i])
                pin_in[i] = drv_val[i];
            else if (pull_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last[i];
        end
    end
endmodule : tpc_pins
`default_nettype wire

//--- tb/tpc_core_test.sv
// Self-checking bench of the timer/PWM core driven over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"
module tpc_core_test;
    localparam logic [31:0] SC = `TPC_SC_OFF, CNT = `TPC_CNT_OFF, MDL = `TPC_MOD_OFF;
    localparam logic [31:0] C0 = `TPC_CH_BASE, C1 = C0 + `TPC_CH_STRIDE, V1 = C1 + `TPC_CHV_OFF;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, err, fix_clk, ovf_irq;
    logic [31:0] paddr, pwdata, prdata, q, q0, seed, gseed;
    logic [1:0]  pin_in, pin_out, pin_oe, pull_en, ch_irq, gd, gdir;
    logic [1:0]  mask, ext_en, drv_en, drv_val;
    logic [3:0]  fdiv;
    int          fails, checks, hi, tg;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Wide enough to hold a response flag above a full data word.
    task automatic chk(input logic [63:0] got, lo, hi_b, input string m);
        checks++;
        if ((got >= lo && got <= hi_b) !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h..%h", $time, m, got, lo, hi_b);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees the answer.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic clr_flag(input logic [31:0] a);
        apb(1'b0, a, 0);
        apb(1'b1, a, q & ~32'h80);
    endtask : clr_flag
    task automatic count(input int n);
        logic p;
        hi = 0;
        tg = 0;
        p = pin_out[1];
        repeat (n) begin
            @(negedge clk);
            hi += pin_out[1];
            tg += (pin_out[1] != p);
            p = pin_out[1];
        end
    endtask : count
    tpc_core i_tpc_core (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fixed_system_clock(fix_clk), .channel_pin_in(pin_in),
        .gpio_data(gd), .gpio_dir(gdir), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .pin_pullup_en(pull_en), .channel_irq(ch_irq), .overflow_irq(ovf_irq));
    tpc_pins i_tpc_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .ext_en(ext_en), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Port data and direction change every cycle so a leak onto an owned pin shows.
    always @(posedge clk) begin
        gseed   <= srst ? xs(32'h00E373DE) : xs(gseed);
        gd      <= gseed[1:0];
        gdir    <= gseed[3:2] & mask;
        fdiv    <= srst ? 4'h0 : fdiv + 4'h1;
        fix_clk <= fdiv[2];
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 64'h0};
        {mask, ext_en, drv_en, drv_val, fails, checks} = {2'h3, 6'h0, 64'h0};
        seed = 32'h00E373DE;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        foreach (seed[i]) if (i < 5) begin
            apb(1'b0, (i < 3) ? 4 * i : C0 + 8 * (i - 3), 0);
            chk(q, 0, 0, "reset value");
        end
        @(negedge clk);
        chk({pin_oe, pin_out, pull_en}, {gdir, gd, 2'h0}, {gdir, gd, 2'h0}, "gpio pins");
        apb(1'b0, 32'h40, 0);
        chk({err, q}, 33'h100000000, 33'h100000000, "unmapped");
        $display("test reset done");
        apb(1'b1, SC, 32'h08);
        apb(1'b0, CNT, 0);
        q0 = q;
        apb(1'b0, CNT, 0);
        chk(q, q0 + 3, q0 + 3, "count rate");
        seed = xs(seed);
        apb(1'b1, CNT, seed);
        apb(1'b0, CNT, 0);
        chk(q, 0, 1, "count clear");
        for (int ps = 0; ps < 8; ps++) begin
            apb(1'b1, MDL, ps[0] ? 32'hFFFF : 32'h0);
            apb(1'b1, SC, 32'h08 | ps);
            apb(1'b1, CNT, 0);
            repeat (512) @(posedge clk);
            apb(1'b0, CNT, 0);
            chk(q, (512 >> ps) - 1, (512 >> ps) + 1, "prescale");
        end
        $display("test prescale done");
        apb(1'b1, MDL, 5);
        apb(1'b1, SC, 32'h08);
        repeat (10) begin
            apb(1'b0, CNT, 0);
            chk(q, 0, 5, "modulo");
        end
        apb(1'b1, SC, 32'h40);
        apb(1'b0, SC, 0);
        chk({q[7], ovf_irq}, 3, 3, "overflow flag");
        apb(1'b1, SC, 32'h40);
        apb(1'b0, SC, 0);
        chk({q, 31'h0, ovf_irq}, 64'h40 << 32, 64'h40 << 32, "flag clear");
        apb(1'b1, MDL, 10);
        apb(1'b1, SC, 32'h28);
        repeat (12) begin
            apb(1'b0, CNT, 0);
            chk(q, 0, 10, "center range");
        end
        $display("test modulo done");
        apb(1'b1, MDL, 15);
        apb(1'b1, SC, 32'h08);
        seed = xs(seed);
        apb(1'b1, V1, seed[3:0]);
        for (int els = 3; els > 0; els--) begin
            apb(1'b1, C1, 32'h10 | (els << 2));
            // Let the first match of the new action land before counting.
            repeat (20) @(posedge clk);
            count(128);
            chk(pin_oe[1], 1, 1, "owned pin");
            if (els > 1)
                chk(hi, (els - 2) * 128, (els - 2) * 128, "set clear");
            else
                chk(tg, 7, 9, "toggle");
        end
        apb(1'b1, V1, 4);
        for (int els = 2; els > 0; els--) begin
            apb(1'b1, C1, 32'h20 | (els << 2));
            repeat (40) @(posedge clk);
            count(128);
            chk(hi, (els == 2) ? 30 : 94, (els == 2) ? 34 : 98, "pwm polarity");
        end
        $display("test outputs done");
        drv_en <= 2'h2;
        for (int els = 1; els < 4; els++) begin
            drv_val <= 2'h0;
            apb(1'b1, C1, 32'h140 | (els << 2));
            clr_flag(C1);
            drv_val <= 2'h2;
            repeat (4) @(posedge clk);
            apb(1'b0, C1, 0);
            chk({q[7], ch_irq[1], pull_en[1]}, {els[0], els[0], 1'b1}, {els[0], els[0], 1'b1},
                "capture rise");
            clr_flag(C1);
            drv_val <= 2'h0;
            repeat (4) @(posedge clk);
            apb(1'b0, C1, 0);
            chk(q[7], els[1], els[1], "capture fall");
        end
        $display("test capture done");
        mask <= 2'h2;
        ext_en <= 2'h1;
        apb(1'b1, C0, 32'h10);
        apb(1'b1, MDL, 0);
        for (int cs = 3; cs > 1; cs--) begin
            apb(1'b1, SC, cs << 3);
            apb(1'b1, CNT, 0);
            repeat (400) @(posedge clk);
            apb(1'b0, CNT, 0);
            chk(q, (cs == 3) ? 98 : 48, (cs == 3) ? 102 : 52, "clock source");
            @(negedge clk);
            chk(pin_oe[0], 0, 0, "shared pin");
        end
        $display("test clocks done");
        end_of_test();
    end
endmodule : tpc_core_test
`default_nettype wire
